/* hw/iwsh_pkg.sv */
// constants for the expansion bus wait-state and address-hold control
package iwsh_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] WAIT_HOLD_OFFSET = 8'h06;
  localparam logic [7:0] WAIT_HOLD_RESET = 8'h00;
  localparam int NARROW_LO_BIT = 2;
  localparam int WIDE_LO_BIT = 4;
  localparam int HOLD_BIT = 7;
  localparam logic [2:0] NARROW_WAIT_BASE = 3'h5;
  localparam logic [2:0] WIDE_WAIT_BASE = 3'h3;
  localparam logic [3:0] HOLD_EXTRA_HALVES = 4'h2;
  localparam logic [3:0] HOLD_NONE_HALVES = 4'h0;
  typedef enum logic [1:0] {IWSH_IDLE, IWSH_ALIGN, IWSH_CMD, IWSH_RECOVER} iwsh_state_t;
endpackage

/* hw/iwsh_control.sv */
// expansion bus cycle sequencer with programmable wait states and address hold
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - narrow cycles wait 5,4,3,2 clocks by bits 3:2
// - wide cycles wait 3,2,1,0 clocks by bits 5:4
// - bit 7 delays ready one clock after command
// - register resets to zero
// - address hold off until bit 7 set
// - sequencer runs at twice bus clock
module iwsh_control (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [iwsh_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [iwsh_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [iwsh_pkg::DATA_W-1:0] o_reg_rdata,
  input wire logic i_cycle_start,
  input wire logic i_cycle_wide,
  output logic o_expansion_bus_clock,
  output logic o_command,
  output logic o_ready,
  output logic o_busy
);
  import iwsh_pkg::*;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [DATA_W-1:0] wait_hold;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wait_hold <= WAIT_HOLD_RESET;
    end else if (i_reg_write && i_reg_addr == WAIT_HOLD_OFFSET) begin
      wait_hold <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_reg_rdata <= '0;
    end else if (i_reg_read && i_reg_addr == WAIT_HOLD_OFFSET) begin
      o_reg_rdata <= wait_hold;
    end else begin
      o_reg_rdata <= '0;
    end
  end

  // ------------------------------------------------------------
  // wait decode
  // ------------------------------------------------------------
  iwsh_state_t state;
  logic [3:0] count;
  logic cyc_wide;
  logic cyc_hold;
  logic [2:0] cyc_waits;
  logic [1:0] narrow_code;
  logic [1:0] wide_code;
  logic [2:0] narrow_waits;
  logic [2:0] wide_waits;
  logic [2:0] next_waits;
  logic [3:0] next_halves;

  // only the documented fields are looked at
  assign narrow_code = wait_hold[NARROW_LO_BIT +: 2];
  assign wide_code = wait_hold[WIDE_LO_BIT +: 2];
  assign narrow_waits = NARROW_WAIT_BASE - {1'b0, narrow_code};
  assign wide_waits = WIDE_WAIT_BASE - {1'b0, wide_code};
  // picked at request time, so a later write cannot stretch a running cycle
  assign next_waits = i_cycle_wide ? wide_waits : narrow_waits;
  // command spans one bus clock plus the waits, in half clocks
  assign next_halves = 4'({cyc_waits + 3'h1, 1'b0} - 4'h1);

  // ------------------------------------------------------------
  // bus clock, sequencer at twice its rate
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_expansion_bus_clock <= 1'b0;
    end else begin
      o_expansion_bus_clock <= ~o_expansion_bus_clock;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state <= IWSH_IDLE;
      count <= '0;
      cyc_wide <= 1'b0;
      cyc_hold <= 1'b0;
      cyc_waits <= '0;
      o_command <= 1'b0;
      o_ready <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_ready <= 1'b0;
      case (state)
        IWSH_IDLE: begin
          if (i_cycle_start) begin
            cyc_wide <= i_cycle_wide;
            cyc_hold <= wait_hold[HOLD_BIT];
            cyc_waits <= next_waits;
            o_busy <= 1'b1;
            state <= IWSH_ALIGN;
          end
        end
        IWSH_ALIGN: begin
          // start the command on a rising bus clock edge
          if (!o_expansion_bus_clock) begin
            o_command <= 1'b1;
            count <= next_halves;
            state <= IWSH_CMD;
          end
        end
        IWSH_CMD: begin
          if (count == 4'h0) begin
            o_command <= 1'b0;
            count <= cyc_hold ? HOLD_EXTRA_HALVES : HOLD_NONE_HALVES;
            state <= IWSH_RECOVER;
          end else begin
            count <= count - 4'h1;
          end
        end
        IWSH_RECOVER: begin
          if (count == 4'h0) begin
            o_ready <= 1'b1;
            o_busy <= 1'b0;
            state <= IWSH_IDLE;
          end else begin
            count <= count - 4'h1;
          end
        end
        default: begin
          state <= IWSH_IDLE;
          o_command <= 1'b0;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [3:0] cmd_len;
  logic [1:0] cyc_code;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cmd_len <= '0;
      cyc_code <= '0;
    end else if (state == IWSH_IDLE && i_cycle_start) begin
      cmd_len <= '0;
      cyc_code <= i_cycle_wide ? wide_code : narrow_code;
    end else if (o_command) begin
      cmd_len <= cmd_len + 4'h1;
    end
  end

  a_narrow_wait_len: assert property (@(posedge i_clock) disable iff (i_reset)
    $fell(o_command) && !cyc_wide |-> cmd_len == 4'({3'h6 - {1'b0, cyc_code}, 1'b0}))
    else $error("narrow command length wrong");

  a_wide_wait_len: assert property (@(posedge i_clock) disable iff (i_reset)
    $fell(o_command) && cyc_wide |-> cmd_len == 4'({3'h4 - {1'b0, cyc_code}, 1'b0}))
    else $error("wide command length wrong");

  a_hold_extra_ready: assert property (@(posedge i_clock) disable iff (i_reset)
    $fell(o_command) && cyc_hold |-> !o_ready ##1 !o_ready ##1 !o_ready ##1 o_ready)
    else $error("held ready not three cycles after command");

  a_hold_off_ready: assert property (@(posedge i_clock) disable iff (i_reset)
    $fell(o_command) && !cyc_hold |-> ##1 o_ready)
    else $error("ready not one cycle after command");

  a_reset_reg_zero: assert property (@(posedge i_clock)
    $past(i_reset) && !i_reset |-> wait_hold == 8'h00 && o_command == 1'b0)
    else $error("register not zero after reset");

  a_bus_clock_half: assert property (@(posedge i_clock) disable iff (i_reset)
    $rose(o_command) |-> o_expansion_bus_clock ##1 !o_expansion_bus_clock)
    else $error("command not aligned to bus clock");

  a_reserved_ignored: assert property (@(posedge i_clock) disable iff (i_reset)
    $rose(o_command) |->
      count == 4'({(cyc_wide ? 3'h4 : 3'h6) - {1'b0, cyc_code}, 1'b0} - 4'h1))
    else $error("wait count not from fields");

  a_bus_clock_toggle: assert property (@(posedge i_clock) disable iff (i_reset)
    !$past(i_reset) |-> o_expansion_bus_clock != $past(o_expansion_bus_clock))
    else $error("bus clock did not toggle");

  a_cmd_end_aligned: assert property (@(posedge i_clock) disable iff (i_reset)
    $fell(o_command) |-> o_expansion_bus_clock)
    else $error("command did not end on a bus clock edge");

  a_busy_on_start: assert property (@(posedge i_clock) disable iff (i_reset)
    !o_busy && i_cycle_start |=> o_busy)
    else $error("request not taken");

  a_idle_quiet: assert property (@(posedge i_clock) disable iff (i_reset)
    !o_busy |-> !o_command)
    else $error("command outside a cycle");

  a_ready_single: assert property (@(posedge i_clock) disable iff (i_reset)
    o_ready |=> !o_ready)
    else $error("ready longer than one cycle");

  a_ready_ends_cycle: assert property (@(posedge i_clock) disable iff (i_reset)
    o_ready |-> !o_busy && !o_command)
    else $error("ready while cycle still open");

  a_refused_keeps_hold: assert property (@(posedge i_clock) disable iff (i_reset)
    o_busy && i_cycle_start |=> $stable(cyc_hold))
    else $error("hold setting changed mid cycle");

endmodule
`default_nettype wire

/* test/iwsh_card_model.sv */
// card-side monitor: command length and ready gap
`timescale 1ns/1ps
`default_nettype none
module iwsh_card_model (
  input wire logic i_clock,
  input wire logic i_start,
  input wire logic i_command,
  input wire logic i_ready,
  output logic [7:0] o_len,
  output logic [7:0] o_gap
);
  always_ff @(posedge i_clock) begin
    if (i_start) begin
      o_len <= 8'h00;
      o_gap <= 8'h00;
    end else if (i_command) begin
      o_len <= o_len + 8'h01;
    end else if (!i_ready && o_len != 8'h00) begin
      o_gap <= o_gap + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* test/test_expansion_bus_wait_hold_hold_control.sv */
// self-checking bench for the wait-state and hold control
`timescale 1ns/1ps
`default_nettype none
module test_expansion_bus_wait_hold_hold_control;
  import iwsh_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_write = 1'b0;
  logic i_reg_read = 1'b0;
  logic i_cycle_start = 1'b0;
  logic i_cycle_wide = 1'b0;
  logic [7:0] o_reg_rdata, c_len, c_gap, d;
  logic o_expansion_bus_clock, o_command, o_ready, o_busy;
  int bad_count = 0;
  int checked = 0;
  logic twice = 1'b0;
  iwsh_control i_iwsh_control (.i_clock(i_clock), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
    .o_reg_rdata(o_reg_rdata), .i_cycle_start(i_cycle_start), .i_cycle_wide(i_cycle_wide),
    .o_expansion_bus_clock(o_expansion_bus_clock), .o_command(o_command),
    .o_ready(o_ready), .o_busy(o_busy));
  iwsh_card_model i_iwsh_card_model (.i_clock(i_clock), .i_start(i_cycle_start),
    .i_command(o_command), .i_ready(o_ready), .o_len(c_len), .o_gap(c_gap));
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  function automatic logic [7:0] exp_len(input logic [7:0] r, input logic w);
    exp_len = w ? 8'(2 * (4 - r[5:4])) : 8'(2 * (6 - r[3:2]));
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= v;
    i_reg_write <= 1'b1;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    @(negedge i_clock);
    chk(o_reg_rdata, e);
  endtask
  task automatic run(input logic w, input logic [7:0] r);
    int n;
    logic pclk;
    logic pcmd;
    @(posedge i_clock);
    i_cycle_start <= 1'b1;
    i_cycle_wide <= w;
    @(posedge i_clock);
    // a held start is a second request while busy, which must be ignored
    i_cycle_start <= twice;
    if (twice) begin
      @(posedge i_clock);
      i_cycle_start <= 1'b0;
    end
    pclk = o_expansion_bus_clock;
    pcmd = 1'b0;
    n = 0;
    while (o_ready !== 1'b1 && n < 40) begin
      @(negedge i_clock);
      n++;
      chk({7'h00, o_expansion_bus_clock}, {7'h00, ~pclk});
      if (o_command === 1'b1 && pcmd !== 1'b1) begin
        chk({7'h00, o_expansion_bus_clock}, 8'h01);
      end
      if (o_ready !== 1'b1) begin
        chk({7'h00, o_busy}, 8'h01);
      end
      pclk = o_expansion_bus_clock;
      pcmd = o_command;
    end
    if (o_ready !== 1'b1) begin
      chk({7'h00, o_ready}, 8'h01);
    end else begin
      chk(c_len, exp_len(r, w));
      chk(c_gap, r[7] ? 8'h03 : 8'h01);
      chk({7'h00, o_busy}, 8'h00);
    end
  endtask
  initial begin
    void'($urandom(24159));
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(8'h06, 8'h00);
    run(1'b0, 8'h00);
    run(1'b1, 8'h00);
    $display("test reset done");
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    rd(8'h06, 8'h00);
    wr(8'h06, 8'h24);
    rd(8'h06, 8'h24);
    run(1'b1, 8'h24);
    wr(8'h06, 8'h80);
    run(1'b0, 8'h80);
    $display("test map done");
    wr(8'h06, 8'hBC);
    @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(8'h06, 8'h00);
    run(1'b0, 8'h00);
    $display("test midreset done");
    for (int i = 0; i < 32; i++) begin
      d = 8'($urandom);
      d[5:2] = 4'(i);
      twice = i[0];
      wr(8'h06, d);
      rd(8'h06, d);
      run(i[4], d);
    end
    $display("test sweep done");
    close_out();
  end
endmodule
`default_nettype wire
